/* tx_part_ptr.sv */
// one partition's line pointer logic for the transmit write port
`timescale 1ns/1ps

module tx_part_ptr #(
    parameter int LINES_W = 3                    // log2 of lines per partition
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   arst_n,
    // events from the write and drain sides
    input  wire logic                   wr_hit,     // accepted word into this partition
    input  wire logic                   word_end,   // that word closes a packet
    input  wire logic                   term_hit,   // forced line termination
    input  wire logic                   rd_hit,     // one committed line taken
    // pointer state
    output logic [tx_fifo_pkg::IDX_W-1:0] word_idx_q,
    output logic [LINES_W-1:0]          wr_line_q,
    output logic [LINES_W-1:0]          rd_line_q,
    output logic [LINES_W:0]            fill_q
);
    import tx_fifo_pkg::*;

    logic advance;  // current line is committed this cycle

    // a line closes on its fourth word, a packet end or a termination
    assign advance = (wr_hit && (word_end || (word_idx_q == LAST_IDX))) || term_hit;

    // word slot within the line being built
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            word_idx_q <= FIRST_IDX;
        end else if (advance) begin
            word_idx_q <= FIRST_IDX;
        end else if (wr_hit) begin
            word_idx_q <= word_idx_q + 2'h1;
        end
    end

    // line pointers wrap inside the partition's own range
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_line_q <= '0;
            rd_line_q <= '0;
        end else begin
            if (advance) begin
                wr_line_q <= wr_line_q + 1'b1;
            end
            if (rd_hit) begin
                rd_line_q <= rd_line_q + 1'b1;
            end
        end
    end

    // committed line count
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fill_q <= '0;
        end else if (advance && !rd_hit) begin
            fill_q <= fill_q + 1'b1;
        end else if (rd_hit && !advance) begin
            fill_q <= fill_q - 1'b1;
        end
    end
endmodule // tx_part_ptr

/* tx_fifo_write_port.sv */
// shared package and write side of one transmit buffer in 32-bit mode, with pointers and full flag
`timescale 1ns/1ps
package tx_fifo_pkg;
    localparam int          PARTS       = 8;      // partitions per buffer
    localparam int          SEL_W       = 3;      // partition select width
    localparam int          DATA_W      = 32;     // user word width
    localparam int          LANE_W      = 4;      // byte lanes per word
    localparam int          PORT_W      = 8;      // logical port tag width
    localparam int          WORDS       = 4;      // words per 128-bit line
    localparam int          IDX_W       = 2;      // word slot index width
    localparam int          BYTES_W     = 3;      // final byte count width
    localparam logic [1:0]  LAST_IDX    = 2'h3;   // fourth slot of a line
    localparam logic [1:0]  FIRST_IDX   = 2'h0;   // first slot of a line
    localparam logic [3:0]  LANES_ALL   = 4'hf;   // four valid bytes
    localparam logic [3:0]  LANES_THREE = 4'he;   // three valid bytes
    localparam logic [3:0]  LANES_ONE   = 4'h8;   // top byte only
    localparam logic [3:0]  LANES_NONE  = 4'h0;   // nothing valid
    localparam logic [2:0]  BYTES_FOUR  = 3'h4;   // end in fourth byte
    localparam logic [2:0]  BYTES_THREE = 3'h3;   // end in third byte
    localparam logic [2:0]  BYTES_ONE   = 3'h1;   // end in first byte
    localparam logic [2:0]  BYTES_NONE  = 3'h0;   // no end marked

    // one stored word with its markers
    typedef struct packed {
        logic [DATA_W-1:0]  data;        // payload
        logic [LANE_W-1:0]  lanes;       // per-byte validity
        logic               first;       // packet start
        logic               last;        // packet end
        logic               bad;         // packet errored
        logic [PORT_W-1:0]  port;        // logical port tag
        logic [BYTES_W-1:0] last_bytes;  // bytes valid in the end word
    } beat_t;

    // one 128-bit line, slot 0 holds the first word
    typedef beat_t [WORDS-1:0] line_t;

    // only three lane patterns are legal
    function automatic logic lanes_legal(input logic [LANE_W-1:0] lanes);
        return (lanes == LANES_ALL) || (lanes == LANES_THREE) || (lanes == LANES_ONE);
    endfunction

    // which byte closes the packet for a given lane pattern
    function automatic logic [BYTES_W-1:0] end_bytes(input logic [LANE_W-1:0] lanes);
        if (lanes == LANES_ALL) begin
            return BYTES_FOUR;
        end else if (lanes == LANES_THREE) begin
            return BYTES_THREE;
        end else if (lanes == LANES_ONE) begin
            return BYTES_ONE;
        end else begin
            return BYTES_NONE;
        end
    endfunction
endpackage

// Summary of operation
// RL1: 3-bit select picks one of eight partitions
// RL2: several ports may share one partition
// RL3: four words build one 128-bit line
// RL4: writer sends four per line unless end
// RL5: lane bit n qualifies byte n
// RL6: all lanes low drops the write
// RL7: writer sets all lanes except last word
// RL8: legal lane patterns 1111, 1110, 1000
// RL9: all lanes on end word: fourth byte last
// RL10: start flag marks packet start for port
// RL11: writer raises start on first line write
// RL12: writer may end packet on any word
// RL13: packet end advances to next line
// RL14: writer raises error only with end
// RL15: strobe high captures the 32-bit word
// RL16: each word tagged with its port number
// RL17: port runs on its own write clock
// RL18: full flag when addressed fill crosses level
// RL19: line termination advances addressed partition pointer
// RL20: everything sampled on write clock rising edge
module tx_fifo_write_port #(
    parameter int LINES_W = 3                           // log2 of lines per partition
) (
    // write clock of this buffer and reset
    input  wire logic                              sys_clk,
    input  wire logic                              arst_n,
    // user write port
    input  wire logic [tx_fifo_pkg::SEL_W-1:0]     tx_partition_select,
    input  wire logic [tx_fifo_pkg::DATA_W-1:0]    tx_write_word,
    input  wire logic [tx_fifo_pkg::LANE_W-1:0]    tx_byte_lane_valid,
    input  wire logic                              tx_packet_first,
    input  wire logic                              tx_packet_last,
    input  wire logic                              tx_packet_bad,
    input  wire logic                              tx_word_strobe,
    input  wire logic [tx_fifo_pkg::PORT_W-1:0]    tx_logical_port_tag,
    input  wire logic                              tx_line_terminate,
    // configuration
    input  wire logic [LINES_W:0]                  full_level,
    // drain side toward the link logic
    input  wire logic                              drain_take,
    input  wire logic [tx_fifo_pkg::SEL_W-1:0]     drain_select,
    output tx_fifo_pkg::line_t                     drain_line,
    output logic                                   drain_valid,
    // status
    output logic                                   tx_partition_full,
    output logic                                   tx_lanes_illegal,
    output logic                                   tx_overflow
);
    import tx_fifo_pkg::*;

    localparam int           LINES     = 1 << LINES_W;           // lines per partition
    localparam int           RAM_LINES = PARTS * LINES;          // lines in the buffer
    localparam int           ADDR_W    = SEL_W + LINES_W;        // line address width
    localparam logic [LINES_W:0] CAP   = (LINES_W+1)'(LINES);   // partition capacity

    // buffer ram, flip-flops addressed by line index
    line_t                       ram_q [RAM_LINES];
    // per-partition pointer state
    logic [IDX_W-1:0]            word_idx [PARTS];
    logic [LINES_W-1:0]          wr_line  [PARTS];
    logic [LINES_W-1:0]          rd_line  [PARTS];
    logic [LINES_W:0]            fill     [PARTS];
    // per-partition event strobes
    logic [PARTS-1:0]            wr_hit;
    logic [PARTS-1:0]            term_hit;
    logic [PARTS-1:0]            rd_hit;
    // decode of the current write
    logic                        has_room;      // addressed partition not full of lines
    logic                        lanes_any;     // at least one lane valid
    logic                        wr_ok;         // word goes into the ram
    logic [ADDR_W-1:0]           wr_addr;       // line being built
    logic [ADDR_W-1:0]           rd_addr;       // line being drained
    beat_t                       new_beat;      // word as stored

    // line address inside the buffer from partition and line
    function automatic logic [ADDR_W-1:0] line_addr(input logic [SEL_W-1:0] part,
                                                   input logic [LINES_W-1:0] line);
        return {part, line};
    endfunction

    // RL1 select addresses partition
    assign has_room  = fill[tx_partition_select] < CAP;
    // RL6 empty lanes drop word
    assign lanes_any = tx_byte_lane_valid != LANES_NONE;
    // RL15 strobe captures word
    assign wr_ok     = tx_word_strobe && lanes_any && has_room;
    assign wr_addr   = line_addr(tx_partition_select, wr_line[tx_partition_select]);
    assign rd_addr   = line_addr(drain_select, rd_line[drain_select]);

    // word as it lands in the line
    always_comb begin
        new_beat      = '0;
        new_beat.data = tx_write_word;
        // RL5 lanes kept per byte
        new_beat.lanes = tx_byte_lane_valid;
        // RL10 start marker stored
        new_beat.first = tx_packet_first;
        new_beat.last  = tx_packet_last;
        // error only meaningful with an end, so it is masked otherwise
        new_beat.bad   = tx_packet_bad && tx_packet_last;
        // RL16 port tag stored
        new_beat.port  = tx_logical_port_tag;
        // RL9 end byte position
        new_beat.last_bytes = tx_packet_last ? end_bytes(tx_byte_lane_valid) : BYTES_NONE;
    end

    // event strobes per partition; the drain never takes from an empty one
    always_comb begin
        for (int p = 0; p < PARTS; p++) begin
            // RL2 any port tag, any partition
            wr_hit[p]   = wr_ok && (tx_partition_select == SEL_W'(p));
            // RL19 termination hits addressed partition
            term_hit[p] = tx_line_terminate && has_room && (tx_partition_select == SEL_W'(p));
            rd_hit[p]   = drain_take && (fill[p] != '0) && (drain_select == SEL_W'(p));
        end
    end

    // RL13 pointer logic per partition
    for (genvar g = 0; g < PARTS; g++) begin : g_part
        tx_part_ptr #(
            .LINES_W    (LINES_W)
        ) u_ptr (
            .sys_clk    (sys_clk),
            .arst_n     (arst_n),
            .wr_hit     (wr_hit[g]),
            .word_end   (tx_packet_last),
            .term_hit   (term_hit[g]),
            .rd_hit     (rd_hit[g]),
            .word_idx_q (word_idx[g]),
            .wr_line_q  (wr_line[g]),
            .rd_line_q  (rd_line[g]),
            .fill_q     (fill[g])
        );
    end

    // RL17 own write clock only
    // RL3 four words per line
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int a = 0; a < RAM_LINES; a++) begin
                ram_q[a] <= '0;
            end
        end else if (wr_ok) begin
            // a new line clears stale slots so a short line reads as unused bytes
            if (word_idx[tx_partition_select] == FIRST_IDX) begin
                ram_q[wr_addr] <= '0;
            end
            ram_q[wr_addr][word_idx[tx_partition_select]] <= new_beat;
        end
    end

    // drained line, held until the next take
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            drain_line  <= '0;
            drain_valid <= 1'b0;
        end else begin
            drain_valid <= |rd_hit;
            if (|rd_hit) begin
                drain_line <= ram_q[rd_addr];
            end
        end
    end

    // RL18 full flag on addressed partition
    // RL20 sampled on write clock
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_partition_full <= 1'b0;
        end else begin
            tx_partition_full <= fill[tx_partition_select] >= full_level;
        end
    end

    // RL8 illegal lane pattern flagged
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_lanes_illegal <= 1'b0;
        end else begin
            // lanes other than all-on are only legal on the end word
            tx_lanes_illegal <= tx_word_strobe && lanes_any &&
                                (!lanes_legal(tx_byte_lane_valid) ||
                                 (!tx_packet_last && tx_byte_lane_valid != LANES_ALL));
        end
    end

    // writes refused for lack of room are reported, not silently lost
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_overflow <= 1'b0;
        end else begin
            tx_overflow <= (tx_word_strobe && lanes_any || tx_line_terminate) && !has_room;
        end
    end

    // checks on the write path
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    empty_lanes_drop_a: assert property ( // RL6
        tx_word_strobe && !lanes_any && !tx_line_terminate
        |=> word_idx[$past(tx_partition_select)] == $past(word_idx[tx_partition_select]))
        else $error("word with no lanes changed the slot index");

    word_capture_a: assert property ( // RL15
        wr_ok |=> ram_q[$past(wr_addr)][$past(word_idx[tx_partition_select])].data
                  == $past(tx_write_word))
        else $error("strobed word not stored");

    port_tag_a: assert property ( // RL16
        wr_ok |=> ram_q[$past(wr_addr)][$past(word_idx[tx_partition_select])].port
                  == $past(tx_logical_port_tag))
        else $error("port tag not stored with word");

    line_of_four_a: assert property ( // RL3
        wr_ok && !tx_packet_last && word_idx[tx_partition_select] != LAST_IDX
        |=> word_idx[$past(tx_partition_select)] == $past(word_idx[tx_partition_select]) + 2'h1)
        else $error("slot index did not step within a line");

    end_advance_a: assert property ( // RL13
        wr_ok && (tx_packet_last || word_idx[tx_partition_select] == LAST_IDX)
        |=> word_idx[$past(tx_partition_select)] == FIRST_IDX &&
            wr_line[$past(tx_partition_select)] == $past(wr_line[tx_partition_select]) + 1'b1)
        else $error("line end did not move the write pointer");

    terminate_advance_a: assert property ( // RL19
        tx_line_terminate && has_room
        |=> wr_line[$past(tx_partition_select)] == $past(wr_line[tx_partition_select]) + 1'b1)
        else $error("termination did not move the write pointer");

    final_byte_a: assert property ( // RL9
        wr_ok && tx_packet_last && tx_byte_lane_valid == LANES_ALL
        |=> ram_q[$past(wr_addr)][$past(word_idx[tx_partition_select])].last_bytes == BYTES_FOUR)
        else $error("end word with all lanes not closed in fourth byte");

    full_flag_a: assert property ( // RL18
        ##1 tx_partition_full == ($past(fill[tx_partition_select]) >= $past(full_level)))
        else $error("full flag does not follow addressed fill");

    lane_pattern_a: assert property ( // RL8
        tx_word_strobe && lanes_any && !lanes_legal(tx_byte_lane_valid) |=> tx_lanes_illegal)
        else $error("illegal lane pattern not flagged");

    first_mark_a: assert property ( // RL10
        wr_ok |=> ram_q[$past(wr_addr)][$past(word_idx[tx_partition_select])].first
                  == $past(tx_packet_first))
        else $error("start marker not stored with word");

    lane_store_a: assert property ( // RL5
        wr_ok |=> ram_q[$past(wr_addr)][$past(word_idx[tx_partition_select])].lanes
                  == $past(tx_byte_lane_valid))
        else $error("lane validity not stored with word");

    lane_nonlast_a: assert property ( // RL7
        tx_word_strobe && lanes_any && !tx_packet_last && tx_byte_lane_valid != LANES_ALL
        |=> tx_lanes_illegal)
        else $error("partial lanes before the end word not flagged");
endmodule // tx_fifo_write_port

/* tx_writer_model.sv */
// user-side writer model feeding the transmit write port
`timescale 1ns/1ps
module tx_writer_model (
    // clock of this buffer
    input  wire logic                           sys_clk,
    // write port toward the buffer
    output logic [tx_fifo_pkg::SEL_W-1:0]       tx_partition_select,
    output logic [tx_fifo_pkg::DATA_W-1:0]      tx_write_word,
    output logic [tx_fifo_pkg::LANE_W-1:0]      tx_byte_lane_valid,
    output logic                                tx_packet_first,
    output logic                                tx_packet_last,
    output logic                                tx_packet_bad,
    output logic                                tx_word_strobe,
    output logic [tx_fifo_pkg::PORT_W-1:0]      tx_logical_port_tag,
    output logic                                tx_line_terminate
);
    import tx_fifo_pkg::*;

    // quiet bus at time zero
    initial begin
        {tx_partition_select, tx_write_word, tx_byte_lane_valid} = '0;
        {tx_packet_first, tx_packet_last, tx_packet_bad} = 3'h0;
        {tx_word_strobe, tx_logical_port_tag, tx_line_terminate} = '0;
    end

    // released lines flip, so a stale word never looks valid
    task automatic idle();
        tx_word_strobe      = 1'b0;
        tx_packet_first     = 1'b0;
        tx_packet_last      = 1'b0;
        tx_packet_bad       = 1'b0;
        tx_line_terminate   = 1'b0;
        tx_write_word       = ~tx_write_word;
        tx_byte_lane_valid  = ~tx_byte_lane_valid;
        tx_logical_port_tag = ~tx_logical_port_tag;
    endtask

    // one word, after gap idle cycles (slow or prompt writer)
    task automatic put(input int gap, input logic [2:0] sel, input logic [31:0] d,
                       input logic [3:0] ln, input logic f, input logic l, input logic b,
                       input logic [7:0] p);
        repeat (gap) begin
            @(negedge sys_clk);
            idle();
        end
        @(negedge sys_clk);
        tx_partition_select = sel;
        tx_write_word       = d;
        tx_byte_lane_valid  = ln;
        tx_packet_first     = f;
        tx_packet_last      = l;
        tx_packet_bad       = b & l;
        tx_logical_port_tag = p;
        tx_line_terminate   = 1'b0;
        tx_word_strobe      = 1'b1;
        @(posedge sys_clk);
    endtask

    task automatic term(input logic [2:0] sel);
        @(negedge sys_clk);
        tx_word_strobe      = 1'b0;
        tx_partition_select = sel;
        tx_line_terminate   = 1'b1;
        @(posedge sys_clk);
    endtask

    // release after a burst; select stays put
    task automatic finish();
        @(negedge sys_clk);
        idle();
    endtask
endmodule // tx_writer_model

/* spi4_tx_fifo_write_port_32b_tb_top.sv */
// self-checking bench for the transmit write port
`timescale 1ns/1ps
module spi4_tx_fifo_write_port_32b_tb_top;
    import tx_fifo_pkg::*;
    localparam int LW = 1;               // two lines per partition, full comes fast
    logic               sys_clk;
    logic               arst_n;
    logic [SEL_W-1:0]   sel;             // partition select
    logic [DATA_W-1:0]  word;            // write data
    logic [LANE_W-1:0]  lanes;           // byte lanes
    logic               first;           // packet start
    logic               last;            // packet end
    logic               bad;             // packet error
    logic               strobe;          // write enable
    logic [PORT_W-1:0]  port;            // port tag
    logic               term;            // line termination
    logic [LW:0]        full_level;      // full threshold
    logic               drain_take;      // drain request
    logic [SEL_W-1:0]   drain_select;    // drain partition
    line_t              drain_line;      // drained line
    line_t              exp;             // expected line
    logic               drain_valid;     // drain answer
    logic               full;            // full flag
    logic               illegal;         // lane pattern fault
    logic               ovf;             // overflow pulse
    int                 err_count = 0;   // mismatches
    int                 n_tests = 0;     // comparisons

    tx_writer_model wr (.sys_clk(sys_clk), .tx_partition_select(sel), .tx_write_word(word),
        .tx_byte_lane_valid(lanes), .tx_packet_first(first), .tx_packet_last(last),
        .tx_packet_bad(bad), .tx_word_strobe(strobe), .tx_logical_port_tag(port),
        .tx_line_terminate(term));

    tx_fifo_write_port #(.LINES_W(LW)) dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .tx_partition_select(sel), .tx_write_word(word), .tx_byte_lane_valid(lanes),
        .tx_packet_first(first), .tx_packet_last(last), .tx_packet_bad(bad),
        .tx_word_strobe(strobe), .tx_logical_port_tag(port), .tx_line_terminate(term),
        .full_level(full_level), .drain_take(drain_take), .drain_select(drain_select),
        .drain_line(drain_line), .drain_valid(drain_valid), .tx_partition_full(full),
        .tx_lanes_illegal(illegal), .tx_overflow(ovf));

    // 10 MHz write clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_beat(input string nm, input beat_t e, input beat_t g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // expected stored word; end byte worked out here, not by the design
    function automatic beat_t mk(input logic [31:0] d, input logic [3:0] ln, input logic f,
                                 input logic l, input logic b, input logic [7:0] p);
        beat_t r;
        r = '{d, ln, f, l, b & l, p, 3'h0};
        if (l) begin
            r.last_bytes = (ln == 4'hf) ? 3'h4 : (ln == 4'he) ? 3'h3 : (ln == 4'h8) ? 3'h1 : 3'h0;
        end
        return r;
    endfunction

    // take one line and compare all four slots, unused ones must be clear
    task automatic drain_chk(input logic [2:0] p, input string nm);
        int k;
        @(negedge sys_clk);
        drain_select = p;
        drain_take = 1'b1;
        @(negedge sys_clk);
        drain_take = 1'b0;
        k = 0;
        while (drain_valid !== 1'b1 && k < 4) begin
            @(negedge sys_clk);
            k++;
        end
        if (k == 4) begin
            err_count++;
            $display("[FAIL] %s expected valid 1 seen 0", nm);
            close_out();
        end else begin
            for (int i = 0; i < WORDS; i++) begin
                chk_beat(nm, exp[i], drain_line[i]);
            end
        end
        exp = '0;
    endtask

    // four back-to-back words build one line without an end marker
    task automatic t_line();
        for (int i = 0; i < WORDS; i++) begin
            wr.put(0, 3'h2, 32'ha0b1c200 + i, 4'hf, i == 0, 1'b0, 1'b0, 8'h21);
            exp[i] = mk(32'ha0b1c200 + i, 4'hf, i == 0, 1'b0, 1'b0, 8'h21);
        end
        wr.finish();
        drain_chk(3'h2, "line");
        $display("test line done");
    endtask

    // each legal end pattern, a dropped word between, ports sharing one partition
    task automatic t_ends();
        logic [3:0] pat [3] = '{4'hf, 4'he, 4'h8};
        for (int i = 0; i < 3; i++) begin
            wr.put(1, 3'h5, 32'h11223344, 4'hf, 1'b1, 1'b0, 1'b0, 8'h40 + i);
            wr.put(0, 3'h5, 32'hdeadbeef, 4'h0, 1'b0, 1'b0, 1'b0, 8'h99);
            wr.put(0, 3'h5, 32'h55667700 + i, pat[i], 1'b0, 1'b1, i[0], 8'h40 + i);
            exp[0] = mk(32'h11223344, 4'hf, 1'b1, 1'b0, 1'b0, 8'h40 + i);
            exp[1] = mk(32'h55667700 + i, pat[i], 1'b0, 1'b1, i[0], 8'h40 + i);
            wr.finish();
            chk_bit("illegal", 1'b0, illegal);
            drain_chk(3'h5, "end");
        end
        $display("test ends done");
    endtask

    // a lone word closed by termination
    task automatic t_term();
        wr.put(2, 3'h3, 32'hc0ffee01, 4'hf, 1'b1, 1'b0, 1'b0, 8'h07);
        exp[0] = mk(32'hc0ffee01, 4'hf, 1'b1, 1'b0, 1'b0, 8'h07);
        wr.term(3'h3);
        wr.finish();
        drain_chk(3'h3, "term");
        $display("test term done");
    endtask

    // fill partition 0 to its level, overrun it, then drain oldest first
    task automatic t_full();
        for (int i = 0; i < 2; i++) begin
            wr.put(1, 3'h0, 32'h0f0f0000 + i, 4'hf, 1'b1, 1'b1, 1'b0, 8'h10);
        end
        wr.finish();
        @(negedge sys_clk);
        chk_bit("full", 1'b1, full);
        wr.put(0, 3'h0, 32'h12345678, 4'hf, 1'b1, 1'b1, 1'b0, 8'h10);
        wr.finish();
        chk_bit("overflow", 1'b1, ovf);
        wr.put(1, 3'h1, 32'h0badf00d, 4'hf, 1'b1, 1'b0, 1'b0, 8'h11);
        wr.finish();
        @(negedge sys_clk);
        chk_bit("full", 1'b0, full);
        for (int i = 0; i < 2; i++) begin
            exp[0] = mk(32'h0f0f0000 + i, 4'hf, 1'b1, 1'b1, 1'b0, 8'h10);
            drain_chk(3'h0, "full");
        end
        $display("test full done");
    endtask

    // a lane pattern outside the legal three, and a partial pattern before the end word, are flagged
    task automatic t_bad();
        wr.put(0, 3'h6, 32'h01020304, 4'h3, 1'b1, 1'b1, 1'b1, 8'h66);
        wr.finish();
        chk_bit("illegal", 1'b1, illegal);
        wr.put(0, 3'h6, 32'h0a0b0c0d, 4'he, 1'b1, 1'b0, 1'b0, 8'h66);
        wr.finish();
        chk_bit("illegal", 1'b1, illegal);
        $display("test bad lanes done");
    endtask

    initial begin
        arst_n = 1'b0;
        drain_take = 1'b0;
        drain_select = 3'h0;
        full_level = 2'h2;
        exp = '0;
        repeat (5) @(negedge sys_clk);
        arst_n = 1'b1;
        t_line();
        t_ends();
        t_term();
        t_full();
        t_bad();
        close_out();
    end
endmodule // spi4_tx_fifo_write_port_32b_tb_top
